/* rtl/sram_port_pkg.sv */
/*
  constants, carriers and state types for the synchronous burst sram port.
  assumes a single clock domain; all carriers are sampled on the rising edge.
*/
package sram_port_pkg;

  // ------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------
  localparam int ADDR_W  = 19;
  localparam int CNT_W   = 2;
  localparam int UPPER_W = ADDR_W - CNT_W;
  localparam int LANES   = 4;
  localparam int LANE_W  = 8;
  localparam int DATA_W  = LANES * LANE_W;
  localparam int CELL_W  = LANE_W + 1;
  localparam int DEPTH   = 2 ** ADDR_W;

  // ------------------------------------------------------------
  // burst counter constants
  // ------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;
  localparam logic [CNT_W-1:0] CNT_STEP = 2'h1;
  localparam logic [CNT_W-1:0] CNT_LAST = 2'h3;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic chip_sel_first_n;
    logic chip_sel_second;
    logic chip_sel_third_n;
  } chip_sel_t;

  // lane_select_n[3:0] = lanes d, c, b, a
  typedef struct packed {
    logic             all_lanes_write_n;
    logic             lane_write_enable_n;
    logic [LANES-1:0] lane_select_n;
  } write_ctl_t;

  typedef enum {PORT_DESELECTED, PORT_ACTIVE} port_state_t;

endpackage

/* rtl/burst_counter.sv */
/*
  two-bit burst counter: holds the first low address bits and a step count.
  assumes load and advance are never both high; the parent guarantees it.
*/
`timescale 1ns/1ps
module burst_counter
  import sram_port_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic             advance,
  input  wire logic             interleaved,
  input  wire logic [CNT_W-1:0] start_bits,
  output logic      [CNT_W-1:0] low_bits
);

  logic [CNT_W-1:0] start_q;
  logic [CNT_W-1:0] start_d;
  logic [CNT_W-1:0] step_q;
  logic [CNT_W-1:0] step_d;
  logic [CNT_W-1:0] lin_bits;

  // ------------------------------------------------------------
  // next state; step wraps in two bits so no carry leaves the group
  // ------------------------------------------------------------
  assign start_d  = load ? start_bits : start_q;                          // [R2]
  assign step_d   = load ? CNT_ZERO : (advance ? step_q + CNT_STEP : step_q); // [R5] [R15]
  assign lin_bits = start_d + step_d;                                     // [R15]
  assign low_bits = interleaved ? (start_d ^ step_d) : lin_bits;          // [R12]

  always_ff @(posedge mclk) begin
    if (rst) begin
      start_q <= CNT_ZERO;
      step_q  <= CNT_ZERO;
    end else begin
      start_q <= start_d;
      step_q  <= step_d;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_LOAD_COUNTER: assert property (@(posedge mclk) disable iff (rst) // [R2]
    load |=> (step_q == CNT_ZERO) && (start_q == $past(start_bits)))
    else $error("burst counter did not load the low address bits");

  AST_ADVANCE_STEP: assert property (@(posedge mclk) disable iff (rst) // [R5]
    (advance && !load) |=> step_q == CNT_W'($past(step_q) + CNT_STEP))
    else $error("burst counter did not step on advance");

  AST_WRAP_GROUP: assert property (@(posedge mclk) disable iff (rst) // [R15]
    (advance && !load && step_q == CNT_LAST) |=> step_q == CNT_ZERO ##1 1'b1)
    else $error("burst counter left its four-location group");

endmodule

/* rtl/sync_burst_sram_port.sv */
/*
  synchronous flow-through burst sram port with its storage array.
  assumes every input but output_enable_n is synchronous to mclk, and the
  burst order strap is held static; the bench resolves the data wires.
*/
// Operation
// (R1) The address is taken on an edge where a recognised strobe is low and all chip selects are active.
// (R2) The two low address bits are loaded into a two-bit burst counter that supplies the low address.
// (R3) Apart from a global write, a lane is written only when its active-low select is low together with the lane write enable.
// (R4) A low global write writes every lane whatever the lane selects and lane write enable say.
// (R5) The burst counter steps on each edge where the active-low advance is low during a burst.
// (R6) A low processor strobe is ignored when the first chip select is high.
// (R7) Chip selects matter only on edges that load a new external address.
// (R8) The part is selected only when first select is low, second is high and third is low.
// (R9) The active-low output enable acts without the clock and turns the data pins around.
// (R10) The first clock of a read leaving the deselected state keeps the data pins undriven.
// (R11) When both strobes are low on one edge only the processor strobe counts.
// (R12) A static strap picks linear order when low and interleaved order when high.
// (R13) Data and parity pins stay undriven during write data and while deselected.
// (R14) The outside master drives the lane write enable low for a lane write.
// (R15) The burst counter wraps inside its group of four and never carries upward.
// (R16) A selected access with neither global nor lane write enable low is a read.
`timescale 1ns/1ps
module sync_burst_sram_port
  import sram_port_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic [UPPER_W-1:0] addr_upper,
  input  wire logic               addr_bit_one,
  input  wire logic               addr_bit_zero,
  input  wire logic               proc_addr_strobe_n,
  input  wire logic               ctrl_addr_strobe_n,
  input  wire logic               burst_advance_n,
  input  wire chip_sel_t          chip_sel,
  input  wire write_ctl_t         write_ctl,
  input  wire logic               output_enable_n,
  input  wire logic               burst_order_strap,
  input  wire logic [DATA_W-1:0]  dq_in,
  output logic      [DATA_W-1:0]  dq_out,
  output logic                    dq_oe,
  input  wire logic [LANES-1:0]   parity_in,
  output logic      [LANES-1:0]   parity_out,
  output logic                    parity_oe
);

  port_state_t        state_q;
  port_state_t        state_d;
  logic [UPPER_W-1:0] upper_q;
  logic               order_q;
  logic               drive_q;
  logic               proc_take;
  logic               ctrl_take;
  logic               addr_load;
  logic               selected;
  logic               start_hit;
  logic               active;
  logic               emerge;
  logic               advance;
  logic               access_now;
  logic [UPPER_W-1:0] access_upper;
  logic [CNT_W-1:0]   access_low;
  logic [ADDR_W-1:0]  access_addr;
  logic               global_wr;
  logic [LANES-1:0]   lane_wr;
  logic               write_now;
  logic               read_now;
  logic               pins_quiet;

  // ------------------------------------------------------------
  // strobe and select decode
  // ------------------------------------------------------------
  assign proc_take = !proc_addr_strobe_n && !chip_sel.chip_sel_first_n;   // [R6] [R11]
  assign ctrl_take = !ctrl_addr_strobe_n && !proc_take;                   // [R11]
  assign addr_load = proc_take || ctrl_take;                              // [R1] [R7]
  assign selected  = !chip_sel.chip_sel_first_n && chip_sel.chip_sel_second
                     && !chip_sel.chip_sel_third_n;                       // [R8]
  assign start_hit = addr_load && selected;                               // [R1]
  assign active    = (state_q == PORT_ACTIVE);
  assign emerge    = start_hit && !active;                                // [R10]

  // selects are looked at only on loading edges; burst edges keep state
  always_comb begin
    state_d = state_q;
    if (addr_load) begin                                                  // [R7]
      state_d = selected ? PORT_ACTIVE : PORT_DESELECTED;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= PORT_DESELECTED;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      upper_q <= '0;
    end else if (start_hit) begin
      upper_q <= addr_upper;                                              // [R1]
    end
  end

  // strap is re-sampled every edge; a change mid-burst is not supported
  always_ff @(posedge mclk) begin
    order_q <= burst_order_strap;                                         // [R12]
  end

  // ------------------------------------------------------------
  // address path
  // ------------------------------------------------------------
  assign advance      = active && !addr_load && !burst_advance_n;         // [R5]
  assign access_now   = start_hit || (active && !addr_load);
  assign access_upper = start_hit ? addr_upper : upper_q;
  assign access_addr  = {access_upper, access_low};

  burst_counter u_burst_counter (
    .mclk        (mclk),
    .rst         (rst),
    .load        (start_hit),
    .advance     (advance),
    .interleaved (order_q),
    .start_bits  ({addr_bit_one, addr_bit_zero}),
    .low_bits    (access_low)
  );

  // ------------------------------------------------------------
  // write qualification
  // ------------------------------------------------------------
  assign global_wr = !write_ctl.all_lanes_write_n;                        // [R4]
  assign write_now = |lane_wr;
  assign read_now  = access_now && !write_now;                            // [R16]

  // ------------------------------------------------------------
  // storage, one array per lane so each lane has a single writer
  // ------------------------------------------------------------
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    logic [CELL_W-1:0] cell_mem [DEPTH];
    logic [CELL_W-1:0] rd_q;

    assign lane_wr[i] = global_wr || (!write_ctl.lane_write_enable_n
                        && !write_ctl.lane_select_n[i]);                  // [R3] [R4] [R14]

    always_ff @(posedge mclk) begin
      if (access_now && lane_wr[i]) begin                                 // [R3]
        cell_mem[access_addr] <= {parity_in[i], dq_in[i*LANE_W +: LANE_W]};
      end
    end

    always_ff @(posedge mclk) begin
      if (rst) begin
        rd_q <= '0;
      end else if (read_now) begin
        rd_q <= cell_mem[access_addr];
      end
    end

    assign dq_out[i*LANE_W +: LANE_W] = rd_q[LANE_W-1:0];
    assign parity_out[i]              = rd_q[LANE_W];
  end

  // ------------------------------------------------------------
  // pin direction
  // ------------------------------------------------------------
  // drive_q clears on writes and deselects; first beat after deselect is masked
  always_ff @(posedge mclk) begin
    if (rst) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= read_now && !emerge;                                     // [R10] [R13]
    end
  end

  // write strobes now low means the master owns the wires this cycle
  assign pins_quiet = active && write_now;                                // [R13]
  assign dq_oe      = drive_q && !output_enable_n && !pins_quiet;         // [R9] [R13]
  assign parity_oe  = dq_oe;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_LOAD_UPPER: assert property (@(posedge mclk) disable iff (rst) // [R1]
    start_hit |=> upper_q == $past(addr_upper))
    else $error("upper address not taken on a selected strobe");

  AST_PROC_IGNORED: assert property (@(posedge mclk) disable iff (rst) // [R6]
    (!proc_addr_strobe_n && chip_sel.chip_sel_first_n && ctrl_addr_strobe_n)
      |=> (state_q == $past(state_q)) && (upper_q == $past(upper_q)))
    else $error("processor strobe acted with first select high");

  AST_PROC_FIRST: assert property (@(posedge mclk) disable iff (rst) // [R11]
    (!proc_addr_strobe_n && !ctrl_addr_strobe_n && selected)
      |-> access_low == {addr_bit_one, addr_bit_zero})
    else $error("both strobes low but the access did not start fresh");

  AST_SELECTS_IDLE: assert property (@(posedge mclk) disable iff (rst) // [R7]
    (active && !addr_load) |=> active)
    else $error("chip selects disturbed a running burst");

  AST_DESELECT: assert property (@(posedge mclk) disable iff (rst) // [R8] [R13]
    (addr_load && !selected) |=> (!active && !dq_oe) ##1 !dq_oe)
    else $error("deselect edge left the part active or driving");

  AST_ALL_LANES: assert property (@(posedge mclk) disable iff (rst) // [R4]
    (access_now && !write_ctl.all_lanes_write_n) |-> (&lane_wr) && !read_now)
    else $error("global write did not write every lane");

  AST_READ_DRIVES: assert property (@(posedge mclk) disable iff (rst) // [R9] [R16]
    (read_now && active && !addr_load) ##1 (!output_enable_n && !pins_quiet)
      |-> dq_oe && parity_oe)
    else $error("read data not driven with output enable low");

  AST_OE_HIGH: assert property (@(posedge mclk) disable iff (rst) // [R9]
    output_enable_n |-> !dq_oe && !parity_oe)
    else $error("pins driven with output enable high");

  AST_EMERGE_MASK: assert property (@(posedge mclk) disable iff (rst) // [R10]
    emerge |=> !dq_oe)
    else $error("pins driven on the first clock after deselect");

  AST_WRITE_QUIET: assert property (@(posedge mclk) disable iff (rst) // [R13]
    (access_now && write_now) |=> !dq_oe)
    else $error("pins driven after a write edge");

endmodule

/* test/bus_master_model.sv */
/*
  bus master model: processor or cache controller on the sram pins.
  assumes the bench calls beat or set_strap once per clock edge it wants.
*/
`timescale 1ns/1ps
module bus_master_model
  import sram_port_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic [DATA_W-1:0] dq_out,
  input  wire logic              dq_oe,
  input  wire logic [LANES-1:0]  parity_out,
  input  wire logic              parity_oe,
  output logic      [ADDR_W-1:0] addr,
  output logic                   proc_n,
  output logic                   ctrl_n,
  output logic                   adv_n,
  output chip_sel_t              cs,
  output write_ctl_t             wc,
  output logic                   oe_n,
  output logic                   strap,
  output logic      [DATA_W-1:0] dq_in,
  output logic      [LANES-1:0]  parity_in
);
  logic [DATA_W+LANES-1:0] wdata;
  logic [DATA_W+LANES-1:0] idle_pat = '0;
  wire                     drive_w = !wc.all_lanes_write_n ||
                                     (!wc.lane_write_enable_n && !(&wc.lane_select_n));

  // --------------------------------------------------------------
  // wire resolution
  // --------------------------------------------------------------
  // released wires toggle so a stale value can never pass for read data
  assign dq_in     = drive_w ? wdata[DATA_W-1:0] : (dq_oe ? dq_out : idle_pat[DATA_W-1:0]);
  assign parity_in = drive_w ? wdata[DATA_W+:LANES] :
                     (parity_oe ? parity_out : idle_pat[DATA_W+:LANES]);

  initial begin
    {addr, proc_n, ctrl_n, adv_n, oe_n, strap} = {19'h0_0000, 5'h1e};
    cs = 3'h5;
    wc = 6'h3f;
    wdata = '0;
  end

  always @(posedge mclk) idle_pat <= ~idle_pat;

  task automatic beat(input logic p, input logic c, input logic v, input chip_sel_t s,
                      input write_ctl_t w, input logic o, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W+LANES-1:0] d);
    @(posedge mclk);
    #2;
    proc_n = p;
    ctrl_n = c;
    adv_n = v;
    cs = s;
    wc = w;
    oe_n = o;
    addr = a;
    wdata = d;
  endtask

  task automatic set_strap(input logic m);
    @(posedge mclk);
    #2;
    strap = m;
  endtask
endmodule

/* test/sync_burst_sram_port_tb.sv */
/*
  self-checking bench for the burst sram port with a cycle model.
  assumes the bus master model drives every pin but mclk and rst and resolves the data wires.
*/
`timescale 1ns/1ps
module sync_burst_sram_port_tb
  import sram_port_pkg::*;
;
  localparam chip_sel_t  SEL = 3'h2;
  localparam write_ctl_t NOW = 6'h3f;
  localparam write_ctl_t GWR = 6'h1f;
  logic mclk, rst, proc_n, ctrl_n, adv_n, oe_n, strap, dq_oe, parity_oe;
  logic [ADDR_W-1:0] addr, key;
  chip_sel_t cs;
  write_ctl_t wc;
  logic [DATA_W-1:0] dq_in, dq_out;
  logic [LANES-1:0] parity_in, parity_out;
  logic [DATA_W+LANES-1:0] mem [logic [ADDR_W-1:0]];
  logic [DATA_W+LANES-1:0] cell_v, exp;
  logic act = 0, drv = 0, was, ld, wr_e, strap_q, wn, amb, eoe;
  logic [UPPER_W-1:0] base;
  logic [CNT_W-1:0] start, cnt, lo;
  int fail_count, num_checks;

  sync_burst_sram_port dut (.mclk(mclk), .rst(rst), .addr_upper(addr[ADDR_W-1:CNT_W]),
    .addr_bit_one(addr[1]), .addr_bit_zero(addr[0]), .proc_addr_strobe_n(proc_n),
    .ctrl_addr_strobe_n(ctrl_n), .burst_advance_n(adv_n), .chip_sel(cs), .write_ctl(wc),
    .output_enable_n(oe_n), .burst_order_strap(strap), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .parity_in(parity_in), .parity_out(parity_out), .parity_oe(parity_oe));
  bus_master_model host (.mclk(mclk), .dq_out(dq_out), .dq_oe(dq_oe), .parity_out(parity_out),
    .parity_oe(parity_oe), .addr(addr), .proc_n(proc_n), .ctrl_n(ctrl_n), .adv_n(adv_n),
    .cs(cs), .wc(wc), .oe_n(oe_n), .strap(strap), .dq_in(dq_in), .parity_in(parity_in));

  initial begin
    mclk = 0;
    forever #10 mclk = ~mclk;
  end

  // --------------------------------------------------------------
  // reference model, updated on the sampling edge
  // --------------------------------------------------------------
  always @(posedge mclk) begin
    wr_e = !wc.all_lanes_write_n || (!wc.lane_write_enable_n && !(&wc.lane_select_n));
    if (rst) begin
      act = 0;
      drv = 0;
      exp = '0;
    end else begin
      was = act;
      ld = (!proc_n && !cs.chip_sel_first_n) || !ctrl_n;
      if (ld) begin
        act = (cs === SEL);
        base = addr[ADDR_W-1:CNT_W];
        start = addr[1:0];
        cnt = CNT_ZERO;
      end else if (act && !adv_n) cnt = cnt + CNT_STEP;
      // a write edge leaves the pins released in the following cycle
      drv = act && was && !wr_e;
      lo = strap_q ? (start ^ cnt) : (start + cnt);
      key = {base, lo};
      if (act && wr_e) begin
        cell_v = mem.exists(key) ? mem[key] : 'x;
        for (int i = 0; i < LANES; i++) begin
          if (!wc.all_lanes_write_n || (!wc.lane_write_enable_n && !wc.lane_select_n[i])) begin
            cell_v[i*LANE_W+:LANE_W] = dq_in[i*LANE_W+:LANE_W];
            cell_v[DATA_W+i] = parity_in[i];
          end
        end
        mem[key] = cell_v;
      end else if (act) exp = mem.exists(key) ? mem[key] : 'x;
    end
    strap_q = strap;
  end

  task automatic check(input string what, input logic [DATA_W+LANES-1:0] e,
                       input logic [DATA_W+LANES-1:0] s);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, e, s);
    end
  endtask

  // outputs are settled and inputs set up by the falling edge
  always @(negedge mclk) begin
    if (!rst) begin
      wn = !wc.all_lanes_write_n || (!wc.lane_write_enable_n && !(&wc.lane_select_n));
      amb = wc.all_lanes_write_n && !wc.lane_write_enable_n && (&wc.lane_select_n);
      eoe = act && drv && !oe_n && !wn;
      if (!amb) check("dq_oe", eoe, dq_oe);
      if (!amb) check("parity_oe", eoe, parity_oe);
      if (!$isunknown(exp)) check("read data", exp, {parity_out, dq_out});
    end
  end

  function automatic logic [DATA_W+LANES-1:0] rnd();
    logic [63:0] r;
    r = {$urandom, $urandom};
    return r[DATA_W+LANES-1:0];
  endfunction

  task automatic end_of_test();
    if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  initial begin
    fail_count = 0;
    num_checks = 0;
    rst = 1;
    void'($urandom(32'ha2e4_74de));
    repeat (4) @(posedge mclk);
    #2 rst = 0;
    host.beat(1, 0, 1, SEL, GWR, 1, 19'h0_0016, rnd());
    repeat (4) host.beat(1, 1, 0, 3'h5, GWR, 1, 19'h0_0000, rnd());
    host.beat(1, 0, 1, 3'h0, NOW, 0, 19'h0_0000, rnd());
    host.beat(1, 0, 1, SEL, NOW, 0, 19'h0_0016, rnd());
    repeat (5) host.beat(1, 1, 0, SEL, NOW, 0, 19'h0_0000, rnd());
    for (int i = 0; i < LANES; i++) host.beat(0, 1, 1, SEL, {2'h2, ~(4'h1 << i)}, 0, 19'h0_0017, rnd());
    host.beat(0, 1, 1, SEL, 6'h30, 0, 19'h0_0017, rnd());
    repeat (2) host.beat(1, 1, 1, SEL, NOW, 0, 19'h0_0000, rnd());
    host.beat(0, 1, 1, 3'h6, NOW, 0, 19'h0_0040, rnd());
    host.beat(0, 0, 1, 3'h6, NOW, 0, 19'h0_0016, rnd());
    for (int i = 0; i < 8; i++) begin
      host.beat(1, 0, 1, i[2:0], NOW, 0, 19'h0_0014, rnd());
      host.beat(1, 1, 0, SEL, NOW, 0, 19'h0_0000, rnd());
    end
    host.set_strap(1);
    host.beat(0, 1, 1, SEL, NOW, 0, 19'h0_0015, rnd());
    repeat (4) host.beat(1, 1, 0, SEL, NOW, 0, 19'h0_0000, rnd());
    host.set_strap(1'($urandom_range(0, 1)));
    // small address window so random reads mostly land on written cells
    repeat (3000) host.beat(1'($urandom_range(0, 1)), 1'($urandom_range(0, 1)),
      1'($urandom_range(0, 1)), ($urandom_range(0, 3) != 0) ? SEL : chip_sel_t'(3'($urandom)),
      $urandom_range(0, 1) ? NOW : write_ctl_t'(6'($urandom)), 1'($urandom_range(0, 1)),
      ADDR_W'($urandom_range(0, 31)), rnd());
    end_of_test();
  end
endmodule
